// file: pwm_wave_counter_tb_top.sv
/*
 * Self-checking bench of the wave counter: register access, compare loads
 * and measured pin waveforms in every counting and load mode.
 * Assumes one 50 MHz clock and the pin load model beside the design.
 */
module pwm_wave_counter_tb_top;
    import pwmwc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [31:0] reg_rdata;
    logic sequence_start_task = 1'b0;
    logic load_valid = 1'b0;
    logic load_ready;
    logic [15:0] load_half0 = 16'h0;
    logic [15:0] load_half1 = 16'h0;
    logic [15:0] load_half2 = 16'h0;
    logic [15:0] load_half3 = 16'h0;
    logic [NUM_CH-1:0] pwm_out;
    logic pwm_running;
    logic clr = 1'b0;
    logic [NUM_CH-1:0][15:0] hi_cnt;
    logic [7:0] rise_cnt;
    int fails = 0;
    int tests_run = 0;

    always #10 clk = ~clk;

    pwmwc_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .sequence_start_task(sequence_start_task), .load_valid(load_valid),
        .load_ready(load_ready), .load_half0(load_half0), .load_half1(load_half1),
        .load_half2(load_half2), .load_half3(load_half3), .pwm_out(pwm_out),
        .pwm_running(pwm_running));

    pwmwc_pin_load pins (.clk(clk), .rst_n(rst_n), .pwm_out(pwm_out), .clr(clr),
        .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask

    // A hang on back-pressure ends the run rather than stalling it.
    task automatic wait_ready();
        int i;
        i = 0;
        while (load_ready !== 1'b1 && i < 50) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (load_ready !== 1'b1) begin
            fails++;
            summarize();
        end
    endtask

    task automatic load(input logic [15:0] a, b, c, d);
        load_half0 <= a;
        load_half1 <= b;
        load_half2 <= c;
        load_half3 <= d;
        load_valid <= 1'b1;
        #1;
        wait_ready();
        @(posedge clk);
        load_valid <= 1'b0;
        #1;
    endtask

    task automatic go(input logic [31:0] ctrl, top, input logic [15:0] a, b, c, d);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_TOP, top);
        wr(OFS_CTRL, ctrl);
        load(a, b, c, d);
        sequence_start_task <= 1'b1;
        @(posedge clk);
        sequence_start_task <= 1'b0;
        #1;
        check(32'(pwm_running), 32'h1);
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Windows hold whole periods, so counts do not depend on the phase.
    task automatic meas(input int n, input logic [15:0] h0, h1, h2, h3, input logic [7:0] r);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        check(32'(hi_cnt[0]), 32'(h0));
        check(32'(hi_cnt[1]), 32'(h1));
        check(32'(hi_cnt[2]), 32'(h2));
        check(32'(hi_cnt[3]), 32'(h3));
        check(32'(rise_cnt), 32'(r));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_TOP, 32'(TOP_RST));
        rd(OFS_STATUS, 32'h0);
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, 32'h0);
        wr(OFS_TOP, 32'hffffffff);
        rd(OFS_TOP, 32'h00007fff);
        $display("test regs done");
    endtask

    task automatic t_up();
        go(32'h1, 32'ha, 16'h8000, 16'h8004, 16'h800a, 16'h0004);
        meas('h64, 16'h0, 16'h28, 16'h64, 16'h3c, 8'h0a);
        wr(OFS_TOP, 32'h14);
        meas('h64, 16'h0, 16'h28, 16'h64, 16'h3c, 8'h0a);
        load(16'h8000, 16'h8004, 16'h800a, 16'h0004);
        wait_ready();
        repeat (2) @(posedge clk);
        meas('hc8, 16'h0, 16'h28, 16'h64, 16'ha0, 8'h0a);
        $display("test up done");
    endtask

    task automatic t_updn();
        go(32'h3, 32'h8, 16'h8000, 16'h8003, 16'h8009, 16'h0003);
        meas('ha0, 16'h0, 16'h32, 16'ha0, 16'h6e, 8'h0a);
        $display("test updown done");
    endtask

    task automatic t_presc();
        go(32'h5, 32'ha, 16'h8000, 16'h8004, 16'h800a, 16'h8004);
        meas('hc8, 16'h0, 16'h50, 16'hc8, 16'h50, 8'h0a);
        $display("test prescaler done");
    endtask

    task automatic t_wave();
        go(32'h21, 32'ha, 16'h8002, 16'h8003, 16'h8006, 16'h8006);
        meas('h3c, 16'h14, 16'h1e, 16'h3c, 16'h28, 8'h0a);
        $display("test load_mode_a done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_regs();
        t_up();
        t_updn();
        t_presc();
        t_wave();
        summarize();
    end
endmodule

// file: pwmwc_pin_load.sv
/*
 * Model of the loads on the four channel pins: counts high cycles of every
 * pin and rising edges of pin 1 over a window opened by clr.
 * Assumes the pins are sampled on clk, the clock of the wave counter.
 */
module pwmwc_pin_load
    import pwmwc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_CH-1:0] pwm_out,
    input wire logic clr,
    output logic [NUM_CH-1:0][15:0] hi_cnt,
    output logic [7:0] rise_cnt
);
    logic [NUM_CH-1:0] prev;

    ////////////////////////////////////////////////////////////////////////
    // The previous level keeps updating during clr so no false edge is seen.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= '0;
            hi_cnt <= '0;
            rise_cnt <= 8'h00;
        end else begin
            prev <= pwm_out;
            if (clr) begin
                hi_cnt <= '0;
                rise_cnt <= 8'h00;
            end else begin
                for (int i = 0; i < NUM_CH; i++) begin
                    hi_cnt[i] <= hi_cnt[i] + 16'(pwm_out[i]);
                end
                if (pwm_out[1] && !prev[1]) begin
                    rise_cnt <= rise_cnt + 8'h01;
                end
            end
        end
    end
endmodule

// file: pwmwc_pkg.sv
/*
 * Constants shared by the wave counter: register offsets, field positions,
 * values after reset and the encoding of the memory parameter half word.
 * Assumes a single 50 MHz clock domain and a decoder on the same clock.
 */
package pwmwc_pkg;

    localparam int CNT_W = 15;
    localparam int NUM_CH = 4;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TOP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Control register fields.
    localparam int CTRL_EN_POS = 0;
    localparam int CTRL_UPDN_POS = 1;
    localparam int CTRL_PRESC_POS = 2;
    localparam int CTRL_WAVE_POS = 5;

    // Status register fields.
    localparam int ST_DOWN_POS = 15;
    localparam int ST_RUN_POS = 16;
    localparam int ST_OUT_POS = 17;
    localparam int ST_PEND_POS = 21;

    // Memory parameter half word: polarity on top, compare value below.
    localparam int PARAM_POL_POS = 15;

    localparam logic [CNT_W-1:0] TOP_RST = 15'h3e80;
    localparam logic [2:0] PRESC_RST = 3'h0;

endpackage

// file: pwmwc_top.sv
/*
 * Wave counter of a four channel pulse width modulator, with its software
 * registers and the compare load path from the decoder.
 * Assumes the decoder and the register master run on clk and hold their
 * own sequencing; the outputs go straight to the assigned pins.
 */
// What this block does
// - One shared 15-bit counter, four compare channels.
// - Each channel drives its own output pin.
// - Polarity comes from the fetched parameter.
// - Mode bit selects up or up-down counting.
// - Top value and prescaler set the period.
// - Top below compare: no edges, held high.
// - Compare registers loaded only by decoder.
// - Top register writable any time without glitches.
// - Load_mode_a mode takes top from memory.
// - Otherwise top sampled at start and loads.
// - Up mode wraps to zero, outputs invert.
// - Compare zero low, compare top high.
// - Up counting gives edge aligned pulses.
// - Up period is top divided cycles.
// - Up-down counts back, center aligned pulses.
// - Up-down period is twice top cycles.
// - Fetched updates applied glitch free per period.
// - Load_mode_a groups: three compares, fourth top.
module pwmwc_top
    import pwmwc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic sequence_start_task,
    input wire logic load_valid,
    output logic load_ready,
    input wire logic [15:0] load_half0,
    input wire logic [15:0] load_half1,
    input wire logic [15:0] load_half2,
    input wire logic [15:0] load_half3,
    output logic [NUM_CH-1:0] pwm_out,
    output logic pwm_running
);

    initial begin
        if (ADDR_W < 8) begin
            $error("pwmwc_top: ADDR_W must be at least 8");
        end
    end

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic enable;
        logic count_up_then_down;
        logic [2:0] presc;
        logic load_mode_a;
        logic [CNT_W-1:0] counter_top_value;
        logic [CNT_W-1:0] top_act;
        logic [CNT_W-1:0] pend_top;
        logic [NUM_CH-1:0][15:0] cmp;
        logic [NUM_CH-1:0][15:0] pend;
        logic pend_valid;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic [6:0] presc_cnt;
        logic running;
        logic [NUM_CH-1:0] out;
        logic [31:0] rdata;
    } pwmwc_state_t;

    pwmwc_state_t s;
    pwmwc_state_t next_s;

    logic [6:0] presc_mask;
    logic tick;
    logic at_top;
    logic period_end;
    logic go_start;
    logic load_acc;
    logic sel_ctrl;
    logic sel_top;
    logic sel_status;
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0][15:0] in_half;

    assign in_half = {load_half3, load_half2, load_half1, load_half0};
    assign presc_mask = 7'(({7'h00, 1'b1} << s.presc) - 8'h01);
    assign tick = s.running && (s.presc_cnt == presc_mask);
    assign at_top = ({1'b0, s.cnt} + 16'h0001) >= {1'b0, s.top_act};
    assign period_end = tick && (s.count_up_then_down ? (s.down && s.cnt <= 15'h0001)
                                                       : at_top);
    assign go_start = sequence_start_task && s.enable && !s.running;
    assign load_ready = !s.pend_valid;
    assign load_acc = load_valid && load_ready;
    assign sel_ctrl = (reg_addr == ADDR_W'(OFS_CTRL));
    assign sel_top = (reg_addr == ADDR_W'(OFS_TOP));
    assign sel_status = (reg_addr == ADDR_W'(OFS_STATUS));

    ////////////////////////////////////////////////////////////////////////
    // Per channel compare against the shared counter.

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic [CNT_W-1:0] cval;
            logic raw;
            assign cval = s.cmp[gi][CNT_W-1:0];
            // Zero wins so that a zero compare stays low even with a zero top.
            assign raw = (cval != 15'h0000) &&
                         ((s.cnt < cval) || (cval >= s.top_act));
            assign level[gi] = s.cmp[gi][PARAM_POL_POS] ? raw : !raw;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0000_0000;

        if (reg_we && sel_ctrl) begin
            next_s.enable = reg_wdata[CTRL_EN_POS];
            next_s.count_up_then_down = reg_wdata[CTRL_UPDN_POS];
            next_s.presc = reg_wdata[CTRL_PRESC_POS +: 3];
            next_s.load_mode_a = reg_wdata[CTRL_WAVE_POS];
        end
        // Only the shadow is written; the counter sees it at a sample point.
        if (reg_we && sel_top) begin
            next_s.counter_top_value = reg_wdata[CNT_W-1:0];
        end
        if (reg_re) begin
            if (sel_ctrl) begin
                next_s.rdata[CTRL_EN_POS] = s.enable;
                next_s.rdata[CTRL_UPDN_POS] = s.count_up_then_down;
                next_s.rdata[CTRL_PRESC_POS +: 3] = s.presc;
                next_s.rdata[CTRL_WAVE_POS] = s.load_mode_a;
            end else if (sel_top) begin
                next_s.rdata[CNT_W-1:0] = s.counter_top_value;
            end else if (sel_status) begin
                next_s.rdata[CNT_W-1:0] = s.cnt;
                next_s.rdata[ST_DOWN_POS] = s.down;
                next_s.rdata[ST_RUN_POS] = s.running;
                next_s.rdata[ST_OUT_POS +: NUM_CH] = s.out;
                next_s.rdata[ST_PEND_POS] = s.pend_valid;
            end
        end

        // Decoder load: the only way into the compare registers.
        if (load_acc) begin
            next_s.pend_valid = 1'b1;
            next_s.pend = in_half;
            if (s.load_mode_a) begin
                next_s.pend[NUM_CH-1] = s.cmp[NUM_CH-1];
                next_s.pend_top = load_half3[CNT_W-1:0];
            end else begin
                next_s.pend_top = s.counter_top_value;
            end
        end

        // Prescaler and counter.
        if (s.running) begin
            next_s.presc_cnt = tick ? 7'h00 : 7'(s.presc_cnt + 7'h01);
        end
        if (tick) begin
            if (!s.count_up_then_down) begin
                next_s.down = 1'b0;
                next_s.cnt = at_top ? 15'h0000 : 15'(s.cnt + 15'h0001);
            end else if (!s.down) begin
                if (at_top) begin
                    next_s.cnt = s.top_act;
                    next_s.down = 1'b1;
                end else begin
                    next_s.cnt = 15'(s.cnt + 15'h0001);
                end
            end else if (s.cnt <= 15'h0001) begin
                next_s.cnt = 15'h0000;
                next_s.down = 1'b0;
            end else begin
                next_s.cnt = 15'(s.cnt - 15'h0001);
            end
        end

        // New values land only at a period boundary, so no pulse is cut short.
        if ((period_end || go_start) && s.pend_valid) begin
            next_s.cmp = s.pend;
            next_s.top_act = s.pend_top;
            next_s.pend_valid = load_acc;
        end
        if (go_start) begin
            next_s.running = 1'b1;
            next_s.cnt = 15'h0000;
            next_s.down = 1'b0;
            next_s.presc_cnt = 7'h00;
            if (!s.load_mode_a && !s.pend_valid) begin
                next_s.top_act = s.counter_top_value;
            end
        end
        if (!s.enable) begin
            next_s.running = 1'b0;
        end

        next_s.out = s.running ? level : '0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{enable: 1'b0, count_up_then_down: 1'b0, presc: PRESC_RST,
                   load_mode_a: 1'b0, counter_top_value: TOP_RST, top_act: TOP_RST,
                   pend_top: TOP_RST, cmp: '0, pend: '0, pend_valid: 1'b0,
                   cnt: '0, down: 1'b0, presc_cnt: '0, running: 1'b0,
                   out: '0, rdata: '0};
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign pwm_out = s.out;
    assign pwm_running = s.running;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    zero_cmp_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.cmp[0][CNT_W-1:0] == 15'h0000 && s.cmp[0][PARAM_POL_POS]) |=> !pwm_out[0])
        else $error("zero compare did not hold output low");

    top_cmp_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.running && s.cmp[2][PARAM_POL_POS] && s.cmp[2][CNT_W-1:0] != 15'h0000
         && s.cmp[2][CNT_W-1:0] >= s.top_act) |=> pwm_out[2])
        else $error("compare at or above top did not hold output high");

    inv_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.running && !s.cmp[3][PARAM_POL_POS] && s.cmp[3][CNT_W-1:0] != 15'h0000
         && s.cnt < s.cmp[3][CNT_W-1:0] && s.cmp[3][CNT_W-1:0] < s.top_act)
        |=> !pwm_out[3])
        else $error("opposite polarity did not invert");

    up_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !s.count_up_then_down && at_top && !go_start && s.enable)
        |=> s.cnt == 15'h0000)
        else $error("up counter did not wrap to zero at top");

    updn_peak_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && s.count_up_then_down && !s.down && at_top && s.enable && !go_start)
        |=> s.down ##0 s.cnt == $past(s.top_act))
        else $error("up-down counter did not turn at top");

    top_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_we && sel_top && !period_end && !go_start) |=> $stable(s.top_act))
        else $error("top write reached the counter mid period");

    wave_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load_acc && s.load_mode_a) |=> s.pend_top == $past(load_half3[CNT_W-1:0]))
        else $error("load_mode_a top not taken from memory");

    sample_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load_acc && !s.load_mode_a) |=> s.pend_top == $past(s.counter_top_value))
        else $error("top register not sampled on load");

    cmp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!period_end && !go_start) |=> $stable(s.cmp))
        else $error("compare changed inside a period");

    presc_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && s.presc == 3'h1 && s.enable && !sequence_start_task && !reg_we)
        |=> !tick)
        else $error("prescaler ticked too often");

    start_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (go_start && !s.load_mode_a && !s.pend_valid) |=> s.top_act == $past(s.counter_top_value))
        else $error("top register not sampled at start");

    run_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_start |=> (pwm_running && s.cnt == 15'h0000))
        else $error("start did not run the counter from zero");

    stop_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s.enable |=> !pwm_running)
        else $error("disabled block kept running");

    idle_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s.running |=> pwm_out == '0)
        else $error("idle outputs not low");

    up_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !s.count_up_then_down && !at_top && s.enable && !go_start)
        |=> s.cnt == 15'($past(s.cnt) + 15'h0001))
        else $error("up counter did not step by one");

    down_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && s.count_up_then_down && s.down && s.cnt > 15'h0001 && !go_start)
        |=> (s.down && s.cnt == 15'($past(s.cnt) - 15'h0001)))
        else $error("down counter did not step by one");

    down_turn_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && s.count_up_then_down && s.down && s.cnt <= 15'h0001 && !go_start)
        |=> (!s.down && s.cnt == 15'h0000))
        else $error("down counter did not turn at zero");

    updn_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.running && s.count_up_then_down && !s.down) |-> s.cnt <= s.top_act)
        else $error("up-down counter passed the top");

    wave_keep3_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load_acc && s.load_mode_a) |=> s.pend[NUM_CH-1] == $past(s.cmp[NUM_CH-1]))
        else $error("load_mode_a load changed the fourth compare");

    load_take_a: assert property (@(posedge clk) disable iff (!rst_n)
        load_acc |=> (s.pend_valid && s.pend[0] == $past(load_half0)))
        else $error("decoder load not captured");

    apply_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (period_end && s.pend_valid) |=> s.top_act == $past(s.pend_top))
        else $error("pending top not applied at period end");

    pend_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.pend_valid && !period_end && !go_start) |=> s.pend_valid)
        else $error("pending load lost inside a period");

    read_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_re && sel_top) |=> reg_rdata == {17'h00000, $past(s.counter_top_value)})
        else $error("top register read back wrong");

    edge_align_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.running && s.cnt == 15'h0000 && s.cmp[1][PARAM_POL_POS] && s.cmp[2][PARAM_POL_POS]
         && s.cmp[1][CNT_W-1:0] != 15'h0000 && s.cmp[2][CNT_W-1:0] != 15'h0000)
        |=> (pwm_out[1] && pwm_out[2]))
        else $error("channel edges not aligned at wrap");

    tick_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> s.presc_cnt == 7'h00)
        else $error("prescaler did not restart after a tick");

    up_mode_c: cover property (@(posedge clk) disable iff (!rst_n)
        period_end && !s.count_up_then_down);
    updn_mode_c: cover property (@(posedge clk) disable iff (!rst_n)
        period_end && s.count_up_then_down);
    wave_load_c: cover property (@(posedge clk) disable iff (!rst_n)
        period_end && s.pend_valid && s.load_mode_a);
    stall_c: cover property (@(posedge clk) disable iff (!rst_n)
        load_valid && !load_ready);
    start_load_c: cover property (@(posedge clk) disable iff (!rst_n)
        go_start && s.pend_valid);

endmodule
